// [rtl/tcp_pkg.sv]
package tcp_pkg;

  // ==========================================================
  // Register map, byte addresses on the Avalon-MM slave.
  localparam logic [7:0] OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_CMP_A   = 8'h0c;
  localparam logic [7:0] OFS_CMP_B   = 8'h10;
  localparam logic [7:0] OFS_FLAG    = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;

  // ==========================================================
  // Field positions.
  localparam int CA_ACT_A_LSB = 6;
  localparam int CA_ACT_B_LSB = 4;
  localparam int CA_WGM_LSB   = 0;
  localparam int CB_WGM2_BIT  = 3;
  localparam int CB_CS_LSB    = 0;
  localparam int FL_OVF_BIT   = 0;
  localparam int FL_MA_BIT    = 1;
  localparam int FL_MB_BIT    = 2;

  // ==========================================================
  // Reset values and counter limits.
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] RST_FLAGS  = 3'h0;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // ==========================================================
  // Waveform modes; codes 4 and 6 behave as normal mode.
  localparam logic [2:0] WM_NORMAL   = 3'h0;
  localparam logic [2:0] WM_PC_MAX   = 3'h1;
  localparam logic [2:0] WM_CLEAR    = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PC_CMP   = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;

  // ==========================================================
  // Clock select codes and prescaler tick masks.
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PS_M8   = 10'h007;
  localparam logic [9:0] PS_M64  = 10'h03f;
  localparam logic [9:0] PS_M256 = 10'h0ff;
  localparam logic [9:0] PS_M1K  = 10'h3ff;

  // Compare output actions.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TGL  = 2'h1;
  localparam logic [1:0] ACT_CLR  = 2'h2;
  localparam logic [1:0] ACT_SET  = 2'h3;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] mode;
    logic [2:0] cs;
  } tcp_ctrl_t;

endpackage

// [rtl/tcp_timer8.sv]
// Summary of operation
// - Count and two compares are 8-bit registers.
// - Flags readable; each gated by mask bit.
// - Sources: overflow, match A, match B.
// - Tick from prescaler or external pin edge.
// - Clock select zero stops the counter.
// - Count readable and writable without tick.
// - Software count write beats clear or count.
// - Each tick clears, increments or decrements count.
// - Mode field split over control A and B.
// - Bottom is count value zero.
// - Maximum is count value 0xFF.
// - Top is maximum or compare A value.
// - Overflow flag set per mode; requests interrupt.
// - Continuous equality compare for both units.
// - Compare flag set on tick after match.
// - Enabled flag requests; service clears it.
// - Writing one clears a compare flag.
// - Waveform from match, mode, action, extremes.
// - Compares double-buffered only in PWM modes.
// - Buffer transfers to active value at top.
// - Software reaches buffer or active value.
// - Each compare pin drives a waveform.
// - Normal mode counts up, wraps, sets overflow.
// - Clear-on-match mode clears count at A.
// - Count write blocks matches next tick.
// - Action zero leaves output untouched.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
module tcp_timer8 (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Timer pins and interrupt lines
  input  wire logic        ext_count_pin_in,
  input  wire logic [2:0]  irq_ack_in,
  output logic      [2:0]  irq_req_out,
  output logic             wave_out_a_out,
  output logic             wave_out_b_out
);

  // ==========================================================
  // Assertion clock and reset, shared by every property below.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // ==========================================================
  // Bus slave: every access waits exactly one cycle.
  logic       ack_r;
  logic       wr_go;
  logic [7:0] wdat;
  logic       wr_cnt;

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign wr_go  = avs_write_in & ack_r & avs_byteenable_in[0];
  assign wdat   = avs_writedata_in[7:0];
  assign wr_cnt = wr_go & (avs_address_in == tcp_pkg::OFS_COUNT);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
    end
  end

  // ==========================================================
  // Control registers.
  logic [7:0]        ctrl_a_r;
  logic [7:0]        ctrl_b_r;
  logic [2:0]        mask_r;
  tcp_pkg::tcp_ctrl_t ctl;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_a_r <= tcp_pkg::RST_BYTE;
      ctrl_b_r <= tcp_pkg::RST_BYTE;
      mask_r   <= tcp_pkg::RST_FLAGS;
    end else if (wr_go) begin
      case (avs_address_in)
        tcp_pkg::OFS_CTRL_A: ctrl_a_r <= wdat;
        tcp_pkg::OFS_CTRL_B: ctrl_b_r <= {4'h0, wdat[3:0]};
        tcp_pkg::OFS_MASK:   mask_r   <= wdat[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    ctl.act_a = ctrl_a_r[tcp_pkg::CA_ACT_A_LSB +: 2];
    ctl.act_b = ctrl_a_r[tcp_pkg::CA_ACT_B_LSB +: 2];
    ctl.mode  = {ctrl_b_r[tcp_pkg::CB_WGM2_BIT],
                 ctrl_a_r[tcp_pkg::CA_WGM_LSB +: 2]};
    ctl.cs    = ctrl_b_r[tcp_pkg::CB_CS_LSB +: 3];
  end

  // ==========================================================
  // Timer tick selection.
  logic [9:0] presc_r;
  logic       pin_d_r;
  logic       tick;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      presc_r <= 10'h000;
      pin_d_r <= 1'b0;
    end else begin
      presc_r <= presc_r + 10'h001;
      pin_d_r <= ext_count_pin_in;
    end
  end

  always_comb begin
    case (ctl.cs)
      tcp_pkg::CS_STOP:   tick = 1'b0;
      tcp_pkg::CS_DIV1:   tick = 1'b1;
      tcp_pkg::CS_DIV8:   tick = (presc_r & tcp_pkg::PS_M8) == tcp_pkg::PS_M8;
      tcp_pkg::CS_DIV64:  tick = (presc_r & tcp_pkg::PS_M64) == tcp_pkg::PS_M64;
      tcp_pkg::CS_DIV256: tick = (presc_r & tcp_pkg::PS_M256) == tcp_pkg::PS_M256;
      tcp_pkg::CS_DIV1K:  tick = presc_r == tcp_pkg::PS_M1K;
      tcp_pkg::CS_EXT_FALL: tick = pin_d_r & ~ext_count_pin_in;
      tcp_pkg::CS_EXT_RISE: tick = ~pin_d_r & ext_count_pin_in;
      default:            tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Counter unit.
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       up_r;
  logic       blk_r;
  logic [7:0] ocr_act_r [2];
  logic [7:0] ocr_buf_r [2];
  logic       phase;
  logic       fast;
  logic       pwm;
  logic [7:0] top_v;
  logic       at_top;
  logic       at_bot;
  logic       at_max;
  logic       ovf_ev;

  always_comb begin
    phase  = (ctl.mode == tcp_pkg::WM_PC_MAX) | (ctl.mode == tcp_pkg::WM_PC_CMP);
    fast   = (ctl.mode == tcp_pkg::WM_FAST_MAX) | (ctl.mode == tcp_pkg::WM_FAST_CMP);
    pwm    = phase | fast;
    top_v  = ((ctl.mode == tcp_pkg::WM_CLEAR) | (ctl.mode == tcp_pkg::WM_PC_CMP)
             | (ctl.mode == tcp_pkg::WM_FAST_CMP)) ? ocr_act_r[0]
             : tcp_pkg::CNT_MAX;
    at_top = cnt_r == top_v;
    at_bot = cnt_r == tcp_pkg::CNT_BOTTOM;
    at_max = cnt_r == tcp_pkg::CNT_MAX;
    if (phase) begin
      cnt_nxt = (up_r ^ at_top) | (~up_r & at_bot) ? cnt_r + 8'h01
                                                   : cnt_r - 8'h01;
      if (up_r & at_top) begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end else begin
      cnt_nxt = at_top ? tcp_pkg::CNT_BOTTOM : cnt_r + 8'h01;
    end
    if (phase) begin
      ovf_ev = ~up_r & at_bot;
    end else if (ctl.mode == tcp_pkg::WM_CLEAR) begin
      ovf_ev = at_max;
    end else begin
      ovf_ev = at_top;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_r <= tcp_pkg::RST_BYTE;
    end else if (wr_cnt) begin
      cnt_r <= wdat;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      up_r <= 1'b1;
    end else if (!phase) begin
      up_r <= 1'b1;
    end else if (tick && !wr_cnt) begin
      if (up_r && at_top) begin
        up_r <= 1'b0;
      end else if (!up_r && at_bot) begin
        up_r <= 1'b1;
      end
    end
  end

  // A count write masks matches until the next tick has passed.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      blk_r <= 1'b0;
    end else if (wr_cnt) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // ==========================================================
  // Compare units A and B.
  logic [1:0] match;
  logic [1:0] cmp_ev;
  logic [1:0] wave_r;
  logic [1:0] act [2];

  assign act[0] = ctl.act_a;
  assign act[1] = ctl.act_b;

  for (genvar u = 0; u < 2; u++) begin : g_unit
    localparam logic [7:0] OFS = (u == 0) ? tcp_pkg::OFS_CMP_A : tcp_pkg::OFS_CMP_B;
    logic wr_cmp;

    assign wr_cmp   = wr_go & (avs_address_in == OFS);
    assign match[u] = cnt_r == ocr_act_r[u];
    assign cmp_ev[u] = tick & match[u] & ~blk_r & ~wr_cnt;

    // Buffer always holds the last software value, so reads are uniform.
    always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
        ocr_buf_r[u] <= tcp_pkg::RST_BYTE;
      end else if (wr_cmp) begin
        ocr_buf_r[u] <= wdat;
      end
    end

    always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
        ocr_act_r[u] <= tcp_pkg::RST_BYTE;
      end else if (!pwm && wr_cmp) begin
        ocr_act_r[u] <= wdat;
      end else if (pwm && tick && !wr_cnt && at_top) begin
        ocr_act_r[u] <= ocr_buf_r[u];
      end
    end

    always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
        wave_r[u] <= 1'b0;
      end else begin
        if (cmp_ev[u]) begin
          if (phase) begin
            if (act[u] == tcp_pkg::ACT_CLR) begin
              wave_r[u] <= ~up_r;
            end else if (act[u] == tcp_pkg::ACT_SET) begin
              wave_r[u] <= up_r;
            end
          end else if (act[u] == tcp_pkg::ACT_TGL && !fast) begin
            wave_r[u] <= ~wave_r[u];
          end else if (act[u] == tcp_pkg::ACT_CLR) begin
            wave_r[u] <= 1'b0;
          end else if (act[u] == tcp_pkg::ACT_SET) begin
            wave_r[u] <= 1'b1;
          end
        end
        // Fast PWM restarts the pulse as the count returns to bottom.
        if (fast && tick && !wr_cnt && at_top && act[u][1]) begin
          wave_r[u] <= ~act[u][0];
        end
      end
    end
  end

  assign wave_out_a_out = wave_r[0];
  assign wave_out_b_out = wave_r[1];

  // ==========================================================
  // Flags; a hardware set wins over a clear in the same cycle.
  logic [2:0] flag_r;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set = {cmp_ev[1], cmp_ev[0],
                     tick & ~wr_cnt & ovf_ev};
  assign flag_clr = irq_ack_in
                  | ({3{wr_go & (avs_address_in == tcp_pkg::OFS_FLAG)}}
                     & wdat[2:0]);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flag_r <= tcp_pkg::RST_FLAGS;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  assign irq_req_out = flag_r & mask_r;

  // ==========================================================
  // Read data, captured during the wait cycle.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      case (avs_address_in)
        tcp_pkg::OFS_CTRL_A: avs_readdata_out <= {24'h000000, ctrl_a_r};
        tcp_pkg::OFS_CTRL_B: avs_readdata_out <= {24'h000000, ctrl_b_r};
        tcp_pkg::OFS_COUNT:  avs_readdata_out <= {24'h000000, cnt_r};
        tcp_pkg::OFS_CMP_A:  avs_readdata_out <= {24'h000000, ocr_buf_r[0]};
        tcp_pkg::OFS_CMP_B:  avs_readdata_out <= {24'h000000, ocr_buf_r[1]};
        tcp_pkg::OFS_FLAG:   avs_readdata_out <= {29'h0, flag_r};
        tcp_pkg::OFS_MASK:   avs_readdata_out <= {29'h0, mask_r};
        default:             avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Assertions.

  a_stop_holds: assert property (
    ctl.cs == tcp_pkg::CS_STOP && !wr_cnt |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  a_write_wins: assert property (
    wr_cnt |=> cnt_r == $past(wdat))
    else $error("count write lost");
  a_normal_wrap: assert property (
    ctl.mode == tcp_pkg::WM_NORMAL && tick && !wr_cnt && at_max
    |=> cnt_r == 8'h00 && flag_r[0])
    else $error("normal wrap wrong");
  a_match_clear: assert property (
    ctl.mode == tcp_pkg::WM_CLEAR && tick && !wr_cnt && match[0]
    |=> cnt_r == 8'h00)
    else $error("clear on match failed");
  a_match_flag: assert property (
    tick && match[1] && !blk_r && !wr_cnt |=> flag_r[2])
    else $error("match flag not set");
  a_block_match: assert property (
    tick && (blk_r || wr_cnt) |=> !$rose(flag_r[1]) && !$rose(flag_r[2]))
    else $error("match not blocked");
  a_w1c_clear: assert property (
    wr_go && avs_address_in == tcp_pkg::OFS_FLAG && wdat[1] && !cmp_ev[0]
    |=> !flag_r[1])
    else $error("flag not cleared");
  a_buf_hold: assert property (
    pwm && !(tick && at_top) |=> $stable(ocr_act_r[0]) && $stable(ocr_act_r[1]))
    else $error("buffer moved off top");
  a_act_none: assert property (
    ctl.act_b == tcp_pkg::ACT_NONE && $stable(ctl.act_b) |=> $stable(wave_r[1]))
    else $error("output moved with no action");
  a_bus_wait: assert property (
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait longer than one cycle");
  a_ovf_w1c: assert property (
    wr_go && avs_address_in == tcp_pkg::OFS_FLAG && wdat[0] && !flag_set[0]
    |=> !flag_r[0])
    else $error("overflow flag not cleared");
  a_zero_keeps: assert property (
    wr_go && avs_address_in == tcp_pkg::OFS_FLAG && !wdat[1] && !irq_ack_in[1]
    && flag_r[1] |=> flag_r[1])
    else $error("flag lost on zero write");
  a_ack_clear: assert property (
    irq_ack_in[2] && !cmp_ev[1] |=> !flag_r[2])
    else $error("serviced flag not cleared");

  c_normal_ovf: cover property (ctl.mode == tcp_pkg::WM_NORMAL && $rose(flag_r[0]));
  c_clear_wrap: cover property (ctl.mode == tcp_pkg::WM_CLEAR && $rose(flag_r[1]));
  c_pwm_reload: cover property (pwm && $changed(ocr_act_r[0]));
  c_pc_turn:    cover property (phase && $fell(up_r));
  c_irq_b:      cover property ($rose(irq_req_out[2]));

endmodule  // tcp_timer8

// [testbench/tcp_timer8_bench.sv]
module tcp_timer8_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] R_CTA = tcp_pkg::OFS_CTRL_A;
  localparam logic [7:0] R_CTB = tcp_pkg::OFS_CTRL_B;
  localparam logic [7:0] R_CNT = tcp_pkg::OFS_COUNT;
  localparam logic [7:0] R_CA  = tcp_pkg::OFS_CMP_A;
  localparam logic [7:0] R_CB  = tcp_pkg::OFS_CMP_B;
  localparam logic [7:0] R_FLG = tcp_pkg::OFS_FLAG;
  localparam logic [7:0] R_MSK = tcp_pkg::OFS_MASK;

  logic        clk_in    = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  be        = 4'hf;
  logic        ext_pin   = 1'b0;
  logic [2:0]  ack       = 3'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [2:0]  irq;
  logic        wav_a;
  logic        wav_b;
  logic [7:0]  v;
  int          miscompares = 0;
  int          compares    = 0;
  int          cycles      = 0;
  int          tog_a       = 0;
  int          tog_b       = 0;
  int          high_a      = 0;
  int          dv[4]       = '{8, 64, 256, 1024};

  always #20 clk_in = ~clk_in;

  tcp_timer8 tcp_timer8_inst (
    .clk_in             (clk_in),
    .resetn_in          (resetn_in),
    .avs_address_in     (adr),
    .avs_read_in        (rd),
    .avs_write_in       (wr),
    .avs_writedata_in   (wdat),
    .avs_byteenable_in  (be),
    .avs_readdata_out   (rdat),
    .avs_waitrequest_out(wreq),
    .ext_count_pin_in   (ext_pin),
    .irq_ack_in         (ack),
    .irq_req_out        (irq),
    .wave_out_a_out     (wav_a),
    .wave_out_b_out     (wav_b)
  );

  always @(wav_a) tog_a++;
  always @(wav_b) tog_b++;

  // ==========================================================
  // Watchdog: the whole sequence needs well under 10000 cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (wav_a === 1'b1) high_a++;
    if (cycles == 20000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // ==========================================================
  // Bus access and comparison tasks.
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    compares++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask

  // A fresh edge opens every access so a release is never overwritten in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) rng(32'(n), 0, 63);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // ==========================================================
  // Test sequence.
  initial begin
    idle(10);
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 8'h00);
    chk({5'h0, irq}, 8'h00);
    wr8(R_CNT, 8'h5a);
    wr8(R_CA, 8'ha5);
    wr8(R_CB, 8'h3c);
    wr8(R_MSK, 8'h05);
    rdc(R_CA, 8'ha5);
    rdc(R_CB, 8'h3c);
    rdc(R_MSK, 8'h05);
    idle(20);
    rdc(R_CNT, 8'h5a);
    be <= 4'he;
    wr8(R_CNT, 8'h11);
    be <= 4'hf;
    wr8(8'h1c, 8'hff);
    rdc(8'h1c, 8'h00);
    rdc(R_CNT, 8'h5a);
    // Normal mode wraps through both compare values and the top.
    wr8(R_CNT, 8'hf0);
    wr8(R_CA, 8'hf4);
    wr8(R_CB, 8'hf8);
    wr8(R_MSK, 8'h07);
    wr8(R_CTB, {5'h0, tcp_pkg::CS_DIV1});
    idle(30);
    wr8(R_CTB, 8'h00);
    rdc(R_FLG, 8'h07);
    chk({5'h0, irq}, 8'h07);
    bus(1'b0, R_CNT, 8'h00, v);
    rng(32'(v), 16, 47);
    wr8(R_MSK, 8'h02);
    idle(1);
    chk({5'h0, irq}, 8'h02);
    wr8(R_FLG, 8'h00);
    rdc(R_FLG, 8'h07);
    wr8(R_FLG, 8'h02);
    rdc(R_FLG, 8'h05);
    @(posedge clk_in);
    ack <= 3'h4;
    @(posedge clk_in);
    ack <= 3'h0;
    rdc(R_FLG, 8'h01);
    wr8(R_FLG, 8'h01);
    rdc(R_FLG, 8'h00);
    // Count equal to compare A when written: the first tick must not flag it.
    wr8(R_CA, 8'h40);
    wr8(R_CB, 8'h44);
    wr8(R_CNT, 8'h40);
    wr8(R_CTB, 8'h01);
    idle(12);
    wr8(R_CNT, 8'h80);
    wr8(R_CTB, 8'h00);
    bus(1'b0, R_CNT, 8'h00, v);
    rng(32'(v), 128, 132);
    rdc(R_FLG, 8'h04);
    // Clear-on-match: A toggles every six ticks, B has no action.
    wr8(R_FLG, 8'h07);
    wr8(R_CTA, {tcp_pkg::ACT_TGL, tcp_pkg::ACT_NONE, 2'h0, tcp_pkg::WM_CLEAR[1:0]});
    wr8(R_CA, 8'h05);
    wr8(R_CNT, 8'h00);
    tog_a = 0;
    tog_b = 0;
    wr8(R_CTB, 8'h01);
    idle(60);
    wr8(R_CTB, 8'h00);
    bus(1'b0, R_CNT, 8'h00, v);
    rng(32'(v), 0, 5);
    rdc(R_FLG, 8'h02);
    rng(32'(tog_a), 8, 12);
    rng(32'(tog_b), 0, 0);
    // Fast PWM with top at maximum: high from bottom until the A match.
    wr8(R_CTA, {tcp_pkg::ACT_CLR, tcp_pkg::ACT_NONE, 2'h0, tcp_pkg::WM_FAST_MAX[1:0]});
    wr8(R_CA, 8'h40);
    wr8(R_CNT, 8'h00);
    wr8(R_CTB, 8'h01);
    idle(300);
    high_a = 0;
    idle(512);
    rng(32'(high_a), 120, 140);
    rdc(R_CA, 8'h40);
    // Fast PWM with top at compare A: count never passes 0x40.
    wr8(R_CTB, 8'h00);
    wr8(R_CNT, 8'h00);
    wr8(R_FLG, 8'h07);
    wr8(R_CTB, 8'h09);
    idle(200);
    wr8(R_CTB, 8'h08);
    bus(1'b0, R_CNT, 8'h00, v);
    rng(32'(v), 0, 64);
    rdc(R_FLG, 8'h03);
    // Prescaled ticks; the prescaler free-runs, so allow one tick of phase.
    wr8(R_CTA, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr8(R_CNT, 8'h00);
      wr8(R_CTB, 8'(k + 2));
      idle(1100);
      wr8(R_CTB, 8'h00);
      bus(1'b0, R_CNT, 8'h00, v);
      rng(32'(v), 1096 / dv[k], 1112 / dv[k] + 1);
    end
    // External pin, rising then falling edge, five pulses each.
    for (int k = 7; k >= 6; k--) begin
      wr8(R_CNT, 8'h00);
      wr8(R_CTB, 8'(k));
      repeat (5) begin
        @(posedge clk_in);
        ext_pin <= 1'b1;
        idle(3);
        ext_pin <= 1'b0;
        idle(3);
      end
      wr8(R_CTB, 8'h00);
      rdc(R_CNT, 8'h05);
    end
    // Phase-correct with top at maximum: the count turns at 0xff and runs down.
    wr8(R_FLG, 8'h07);
    wr8(R_CNT, 8'hf0);
    wr8(R_CTA, {tcp_pkg::ACT_CLR, tcp_pkg::ACT_SET, 2'h0, tcp_pkg::WM_PC_MAX[1:0]});
    wr8(R_CTB, 8'h01);
    idle(40);
    wr8(R_CTB, 8'h00);
    bus(1'b0, R_CNT, 8'h00, v);
    rng(32'(v), 224, 230);
    rdc(R_FLG, 8'h00);
    give_verdict();
  end
endmodule // tcp_timer8_bench
